// ==== core/tfc_top.sv ====
// terminal function control: setpoint offset, forced terminal sources and output routing
// Functional notes
// - offset applied only while offset input on
// - direction setting picks add or subtract
// - input function code 50 is offset input
// - offset input off leaves setpoint untouched
// - offset works with any frequency source
// - code 51 forces both sources to terminals
// - release restores programmed source selections
// - change while running stops motor first
// - outputs assignable to two collectors, relay
// - relay defaults alarm, accepts any function
// - any of nine functions drives relay
// - polarity 01 energizes coil when off
// - defaults relay code 05, polarity 01
// - relay code 00 follows run signal
// - alarm still assignable to open collectors
`timescale 1ns/1ns
module tfc_top
    import tfc_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [5:0]       wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic [4:0]       term_in,
    input  wire logic [4:0][15:0] src_freq,
    input  wire logic [3:0]       run_req,
    input  wire logic             motor_running,
    input  wire logic [8:0]       out_func_sig,
    output logic      [15:0]      freq_cmd,
    output logic                  run_cmd,
    output logic                  force_active,
    output logic      [1:0]       oc_out_on,
    output logic                  relay_coil_on
);
    `include "tfc_defines.svh"

    tfc_out_if ob ();

    logic [4:0]  term_meta_r;
    logic [4:0]  term_sync_r;
    logic        ack_r;
    logic [31:0] dat_r;
    logic [2:0]  fsel_r;
    logic [1:0]  rsel_r;
    logic        dir_r;
    logic [4:0][7:0] infn_r;
    tfc_freq_t   ofs_r;
    tfc_freq_t   fmax_r;
    tfc_fsel_t   sel11_r;
    tfc_fsel_t   sel12_r;
    tfc_fsel_t   relay_fn_r;
    logic        relay_pol_r;
    tfc_state_t  state_r;
    logic        force_act_r;
    tfc_freq_t   freq_r;
    tfc_freq_t   freq_nxt;
    logic        run_r;
    logic        run_nxt;
    logic [1:0]  oc_r;
    logic        coil_r;
    logic        add_on;
    logic        force_req;
    logic [2:0]  eff_fsel;
    logic [1:0]  eff_rsel;
    tfc_freq_t   base_freq;
    logic        wr_hit;
    logic [31:0] rd_val;
    logic [31:0] wr_mrg;

    // true when any synchronised terminal programmed with this function code is on
    function automatic logic term_fn(input logic [4:0][7:0] codes, input logic [4:0] lvl,
                                     input logic [7:0] fn);
        term_fn = 1'b0;
        for (int i = 0; i < 5; i++) begin
            if (lvl[i] && codes[i] == fn) begin
                term_fn = 1'b1;
            end
        end
    endfunction

    // byte-lane merge for wishbone writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        for (int b = 0; b < 4; b++) begin
            merge[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
        end
    endfunction

    // offset with saturation; the sum is one bit wider so the top cannot wrap, and subtraction stops at zero
    function automatic tfc_freq_t offset_clamp(input tfc_freq_t base, input tfc_freq_t ofs,
                                               input logic sub, input tfc_freq_t fmax);
        logic [16:0] sum;
        sum = 17'h00000;
        if (sub) begin
            if (ofs > base) begin
                offset_clamp = 16'h0000;
            end else begin
                offset_clamp = base - ofs;
            end
        end else begin
            sum = {1'b0, base} + {1'b0, ofs};
            offset_clamp = (sum > {1'b0, fmax}) ? fmax : sum[15:0];
        end
        if (offset_clamp > fmax) begin
            offset_clamp = fmax;
        end
    endfunction

    // terminals are pins from outside the clock domain
    always_ff @(posedge clk) begin
        if (rst) begin
            term_meta_r <= 5'h00;
            term_sync_r <= 5'h00;
        end else begin
            term_meta_r <= term_in;
            term_sync_r <= term_meta_r;
        end
    end

    // wishbone classic slave: one wait state, ack drops the cycle after it rises
    assign wr_hit = wb_cyc_i && wb_stb_i && !ack_r && wb_we_i;
    // the read mux already holds the addressed register's old contents, so one merge serves the source, offset and maximum registers
    assign wr_mrg = merge(rd_val, wb_dat_i, wb_sel_i);

    always_ff @(posedge clk) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
        end
    end

    always_comb begin
        rd_val = 32'h00000000;
        case (wb_adr_i)
            `TFC_ADR_SRC: begin
                rd_val[`TFC_SRC_FSEL_LSB +: 3] = fsel_r;
                rd_val[`TFC_SRC_RSEL_LSB +: 2] = rsel_r;
                rd_val[`TFC_SRC_DIR_BIT]       = dir_r;
            end
            `TFC_ADR_INFN_A: rd_val = {infn_r[3], infn_r[2], infn_r[1], infn_r[0]};
            `TFC_ADR_INFN_B: rd_val[7:0] = infn_r[4];
            `TFC_ADR_OFS:    rd_val[15:0] = ofs_r;
            `TFC_ADR_FMAX:   rd_val[15:0] = fmax_r;
            `TFC_ADR_OUTCFG: begin
                rd_val[`TFC_OUT_SEL11_LSB +: 4] = sel11_r;
                rd_val[`TFC_OUT_SEL12_LSB +: 4] = sel12_r;
                rd_val[`TFC_OUT_RSEL_LSB +: 4]  = relay_fn_r;
                rd_val[`TFC_OUT_POL_BIT]        = relay_pol_r;
            end
            `TFC_ADR_STATUS: begin
                rd_val[`TFC_ST_FREQ_LSB +: 16] = freq_r;
                rd_val[`TFC_ST_FORCE_BIT]      = force_act_r;
                rd_val[`TFC_ST_ADD_BIT]        = add_on;
                rd_val[`TFC_ST_STOP_BIT]       = (state_r == TFC_STOPPING);
                rd_val[`TFC_ST_RUN_BIT]        = run_r;
            end
            default: rd_val = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dat_r <= 32'h00000000;
        end else if (wb_cyc_i && wb_stb_i && !ack_r && !wb_we_i) begin
            dat_r <= rd_val;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            fsel_r <= `TFC_RST_FSEL;
            rsel_r <= `TFC_RST_RSEL;
            dir_r  <= `TFC_RST_DIR;
            infn_r <= '0;
            ofs_r  <= `TFC_RST_OFS;
            fmax_r <= `TFC_RST_FMAX;
        end else if (wr_hit) begin
            case (wb_adr_i)
                `TFC_ADR_SRC: begin
                    fsel_r <= wr_mrg[`TFC_SRC_FSEL_LSB +: 3];
                    rsel_r <= wr_mrg[`TFC_SRC_RSEL_LSB +: 2];
                    dir_r  <= wr_mrg[`TFC_SRC_DIR_BIT];
                end
                `TFC_ADR_INFN_A: begin
                    for (int b = 0; b < 4; b++) begin
                        if (wb_sel_i[b]) begin
                            infn_r[b] <= wb_dat_i[b*8 +: 8];
                        end
                    end
                end
                `TFC_ADR_INFN_B: begin
                    if (wb_sel_i[0]) begin
                        infn_r[4] <= wb_dat_i[7:0];
                    end
                end
                `TFC_ADR_OFS:  ofs_r  <= wr_mrg[15:0];
                `TFC_ADR_FMAX: fmax_r <= wr_mrg[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sel11_r     <= `TFC_RST_SEL11;
            sel12_r     <= `TFC_RST_SEL12;
            relay_fn_r  <= `TFC_RST_RELAY_FN;
            relay_pol_r <= `TFC_RST_RELAY_POL;
        end else if (wr_hit && wb_adr_i == `TFC_ADR_OUTCFG) begin
            if (wb_sel_i[0]) begin
                sel11_r <= wb_dat_i[`TFC_OUT_SEL11_LSB +: 4];
                sel12_r <= wb_dat_i[`TFC_OUT_SEL12_LSB +: 4];
            end
            if (wb_sel_i[1]) begin
                relay_fn_r  <= wb_dat_i[`TFC_OUT_RSEL_LSB +: 4];
                relay_pol_r <= wb_dat_i[`TFC_OUT_POL_BIT];
            end
        end
    end

    assign add_on    = term_fn(infn_r, term_sync_r, `TFC_FN_ADD);
    assign force_req = term_fn(infn_r, term_sync_r, `TFC_FN_FORCE);

    // the force state only changes here, so sources never swap under a turning motor
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r     <= TFC_FOLLOW;
            force_act_r <= 1'b0;
        end else begin
            case (state_r)
                TFC_FOLLOW: begin
                    if (force_req != force_act_r) begin
                        if (motor_running) begin
                            state_r <= TFC_STOPPING;
                        end else begin
                            force_act_r <= force_req;
                        end
                    end
                end
                TFC_STOPPING: begin
                    if (!motor_running) begin
                        force_act_r <= force_req;
                        state_r     <= TFC_FOLLOW;
                    end
                end
                default: state_r <= TFC_FOLLOW;
            endcase
        end
    end

    always_comb begin
        eff_fsel = force_act_r ? `TFC_SRC_TERMINAL_F : fsel_r;
        eff_rsel = force_act_r ? `TFC_SRC_TERMINAL_R : rsel_r;
        // selector codes past the five sources give a zero setpoint
        base_freq = (eff_fsel < `TFC_NUM_FREQ_SRC) ? src_freq[eff_fsel] : 16'h0000;
        if (add_on) begin
            freq_nxt = offset_clamp(base_freq, ofs_r, dir_r, fmax_r);
        end else begin
            freq_nxt = base_freq;
        end
        // run is withheld until the motor has stopped for a pending source change
        run_nxt = (state_r == TFC_FOLLOW) && (force_req == force_act_r) && run_req[eff_rsel];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            freq_r <= 16'h0000;
            run_r  <= 1'b0;
        end else begin
            freq_r <= freq_nxt;
            run_r  <= run_nxt;
        end
    end

    assign ob.func_sig  = out_func_sig;
    assign ob.sel11     = sel11_r;
    assign ob.sel12     = sel12_r;
    assign ob.relay_fn  = relay_fn_r;
    assign ob.relay_pol = relay_pol_r;

    tfc_out_map u_map (
        .o (ob.map)
    );

    // reset state: alarm off with inverted polarity, so the coil comes up energized
    always_ff @(posedge clk) begin
        if (rst) begin
            oc_r   <= 2'h0;
            coil_r <= `TFC_RST_RELAY_POL;
        end else begin
            oc_r   <= ob.oc_on;
            coil_r <= ob.coil_on;
        end
    end

    assign wb_ack_o      = ack_r;
    assign wb_dat_o      = dat_r;
    assign freq_cmd      = freq_r;
    assign run_cmd       = run_r;
    assign force_active  = force_act_r;
    assign oc_out_on     = oc_r;
    assign relay_coil_on = coil_r;
endmodule

// ==== core/tfc_defines.svh ====
// register offsets, field positions, reset values and function codes for the terminal function block
`ifndef TFC_DEFINES_SVH
`define TFC_DEFINES_SVH

`define TFC_ADR_SRC        6'h00
`define TFC_ADR_INFN_A     6'h04
`define TFC_ADR_INFN_B     6'h08
`define TFC_ADR_OFS        6'h0c
`define TFC_ADR_FMAX       6'h10
`define TFC_ADR_OUTCFG     6'h14
`define TFC_ADR_STATUS     6'h18

`define TFC_SRC_FSEL_LSB   0
`define TFC_SRC_RSEL_LSB   4
`define TFC_SRC_DIR_BIT    8
`define TFC_OUT_SEL11_LSB  0
`define TFC_OUT_SEL12_LSB  4
`define TFC_OUT_RSEL_LSB   8
`define TFC_OUT_POL_BIT    12
`define TFC_ST_FREQ_LSB    0
`define TFC_ST_FORCE_BIT   16
`define TFC_ST_ADD_BIT     17
`define TFC_ST_STOP_BIT    18
`define TFC_ST_RUN_BIT     19

`define TFC_RST_FSEL       3'h0
`define TFC_RST_RSEL       2'h2
`define TFC_RST_DIR        1'h0
`define TFC_RST_OFS        16'h0000
`define TFC_RST_FMAX       16'h1770
`define TFC_RST_SEL11      4'h0
`define TFC_RST_SEL12      4'h1
`define TFC_RST_RELAY_FN   4'h5
`define TFC_RST_RELAY_POL  1'h1

`define TFC_FN_ADD         8'h32
`define TFC_FN_FORCE       8'h33
`define TFC_SRC_TERMINAL_F 3'h1
`define TFC_SRC_TERMINAL_R 2'h1
`define TFC_NUM_FREQ_SRC   3'h5
`define TFC_NUM_OUT_FN     4'h9
`define TFC_RELAY_POL_INV  1'h1

`endif

// ==== core/tfc_pkg.sv ====
// types shared by the terminal function block
package tfc_pkg;
    typedef enum logic [1:0] {
        TFC_FOLLOW   = 2'b00,
        TFC_STOPPING = 2'b01
    } tfc_state_t;

    typedef logic [15:0] tfc_freq_t;
    typedef logic [3:0]  tfc_fsel_t;
endpackage

// ==== core/tfc_out_if.sv ====
// carrier between the control logic and the output function mapper
`timescale 1ns/1ns
interface tfc_out_if;
    import tfc_pkg::*;
    logic [8:0] func_sig;
    tfc_fsel_t  sel11;
    tfc_fsel_t  sel12;
    tfc_fsel_t  relay_fn;
    logic       relay_pol;
    logic [1:0] oc_on;
    logic       coil_on;

    modport ctrl (output func_sig, output sel11, output sel12, output relay_fn, output relay_pol,
                  input oc_on, input coil_on);
    modport map  (input func_sig, input sel11, input sel12, input relay_fn, input relay_pol,
                  output oc_on, output coil_on);
endinterface

// ==== core/tfc_out_map.sv ====
// routes intelligent output functions to the two open-collector outputs and the relay coil
`timescale 1ns/1ns
module tfc_out_map
    import tfc_pkg::*;
(
    tfc_out_if.map o
);
    `include "tfc_defines.svh"

    // codes beyond the nine functions give an inactive signal, so an open collector stays off and the relay coil follows its polarity
    function automatic logic pick(input logic [8:0] sig, input tfc_fsel_t sel);
        pick = (sel < `TFC_NUM_OUT_FN) ? sig[sel] : 1'b0;
    endfunction

    logic relay_sig;

    always_comb begin
        o.oc_on[0] = pick(o.func_sig, o.sel11);
        o.oc_on[1] = pick(o.func_sig, o.sel12);
        relay_sig  = pick(o.func_sig, o.relay_fn);
        // inverted polarity keeps the coil energized while the signal is off
        o.coil_on  = (o.relay_pol == `TFC_RELAY_POL_INV) ? ~relay_sig : relay_sig;
    end
endmodule

// ==== sim/tfc_ext.sv ====
// far-side model: equipment driving the input terminals and the relay contact load
`timescale 1ns/1ns
module tfc_ext (
    input  wire logic       clk,
    input  wire logic [4:0] pin_req,
    input  wire logic       relay_coil_on,
    output logic      [4:0] term_in,
    output logic            relay_no_closed,
    output logic            relay_nc_closed
);
    // pins move just after an edge of the same clock on which the block samples them
    always_ff @(posedge clk) begin
        term_in <= pin_req;
    end
    assign relay_no_closed = relay_coil_on;
    assign relay_nc_closed = !relay_coil_on;
endmodule

// ==== sim/tfc_top_chk.sv ====
// port checker for the terminal function block
`timescale 1ns/1ns
module tfc_top_chk
    import tfc_pkg::*;
(
    input wire logic             clk,
    input wire logic             rst,
    input wire logic             wb_cyc_i,
    input wire logic             wb_stb_i,
    input wire logic             wb_we_i,
    input wire logic [5:0]       wb_adr_i,
    input wire logic [3:0]       wb_sel_i,
    input wire logic [31:0]      wb_dat_i,
    input wire logic [31:0]      wb_dat_o,
    input wire logic             wb_ack_o,
    input wire logic [8:0]       out_func_sig,
    input wire logic             motor_running,
    input wire logic [15:0]      freq_cmd,
    input wire logic             run_cmd,
    input wire logic             force_active,
    input wire logic [1:0]       oc_out_on,
    input wire logic             relay_coil_on
);
    logic [3:0] s11_r;
    logic [3:0] s12_r;
    logic [3:0] rfn_r;
    logic       pol_r;
    logic       wr_cfg;
    logic       e11;
    logic       e12;
    logic       ecoil;
    // shadow of the output routing register, written on the same edge as the block's copy
    assign wr_cfg = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 6'h14;
    assign e11 = s11_r < 4'h9 && out_func_sig[s11_r];
    assign e12 = s12_r < 4'h9 && out_func_sig[s12_r];
    assign ecoil = (rfn_r < 4'h9 && out_func_sig[rfn_r]) ^ pol_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            s11_r <= 4'h0;
            s12_r <= 4'h1;
            rfn_r <= 4'h5;
            pol_r <= 1'b1;
        end else if (wr_cfg) begin
            if (wb_sel_i[0]) begin
                s11_r <= wb_dat_i[3:0];
                s12_r <= wb_dat_i[7:4];
            end
            if (wb_sel_i[1]) begin
                rfn_r <= wb_dat_i[11:8];
                pol_r <= wb_dat_i[12];
            end
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
    coil_map_a: assert property (!$past(rst) |-> relay_coil_on == $past(ecoil))
        else $error("relay coil does not follow function and polarity");
    oc11_map_a: assert property (!$past(rst) |-> oc_out_on[0] == $past(e11))
        else $error("output 11 does not follow its function");
    oc12_map_a: assert property (!$past(rst) |-> oc_out_on[1] == $past(e12))
        else $error("output 12 does not follow its function");
    force_stop_a: assert property ($changed(force_active) |-> !$past(motor_running))
        else $error("source switched while motor driven");
    rst_vals_a: assert property ($past(rst) |-> relay_coil_on && !force_active && !run_cmd)
        else $error("wrong values out of reset");
    rdat_hold_a: assert property (!(wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) |=> $stable(wb_dat_o))
        else $error("read data changed without a read request");
    cover property ($rose(force_active));
    cover property ($fell(relay_coil_on));
    cover property (wb_ack_o && !wb_we_i);
endmodule

bind tfc_top tfc_top_chk chk_i (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .out_func_sig, .motor_running, .freq_cmd, .run_cmd, .force_active, .oc_out_on,
    .relay_coil_on);

// ==== sim/tfc_top_tb.sv ====
// self-checking bench for the terminal function block
`timescale 1ns/1ns
module tfc_top_tb;
    import tfc_pkg::*;
    logic             clk, rst, cyc, stb, we, ack, mrun, coil, no_c, nc_c, force_on, run;
    logic [5:0]       adr;
    logic [3:0]       sel, rreq;
    logic [31:0]      wdat, rdat, q;
    logic [4:0]       pins, term;
    logic [4:0][15:0] srcf;
    logic [8:0]       sig;
    logic [15:0]      freq;
    logic [1:0]       oc;
    int               n_errors, checks_done, cyc_cnt;

    tfc_top uut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .term_in(term), .src_freq(srcf),
        .run_req(rreq), .motor_running(mrun), .out_func_sig(sig), .freq_cmd(freq), .run_cmd(run),
        .force_active(force_on), .oc_out_on(oc), .relay_coil_on(coil));
    tfc_ext ext (.clk(clk), .pin_req(pins), .relay_coil_on(coil), .term_in(term), .relay_no_closed(no_c),
        .relay_nc_closed(nc_c));

    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end

    task automatic results;
        if (n_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            n_errors++;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one classic cycle; the extra edge keeps cyc low at least one cycle between accesses
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        r = rdat;
        cyc <= 0;
        stb <= 0;
        @(posedge clk);
    endtask

    // a pin change needs the partner's edge, two sync flops, the force edge and the output flop
    task automatic settle;
        repeat (8) @(posedge clk);
    endtask

    task automatic t_reset;
        bus(0, 6'h14, 0, q); chk(q, 32'h1510);
        bus(0, 6'h00, 0, q); chk(q, 32'h20);
        bus(0, 6'h10, 0, q); chk(q, 32'h1770);
        bus(0, 6'h1c, 0, q); chk(q, 32'h0);
        chk(no_c, 1'b1);
    endtask

    task automatic t_offset;
        bus(1, 6'h04, 32'h32, q);
        bus(1, 6'h0c, 32'h80, q);
        for (int k = 0; k < 5; k++) begin
            bus(1, 6'h00, k, q);
            pins <= 5'h00;
            settle();
            chk(freq, 16'h0100 * (k + 1));
            pins <= 5'h01;
            settle();
            chk(freq, 16'h0100 * (k + 1) + 16'h80);
        end
        bus(1, 6'h00, 32'h100, q); settle(); chk(freq, 16'h80);
        bus(1, 6'h0c, 32'h200, q); settle(); chk(freq, 16'h0);
        bus(1, 6'h00, 32'h0, q);
        bus(1, 6'h10, 32'h180, q); settle(); chk(freq, 16'h180);
        pins <= 5'h00;
        settle();
        chk(freq, 16'h100);
        bus(1, 6'h08, 32'h32, q);
        pins <= 5'h10;
        settle();
        chk(freq, 16'h180);
        bus(0, 6'h18, 0, q); chk(q, 32'h00020180);
    endtask

    task automatic t_force;
        bus(1, 6'h04, 32'h3300, q);
        bus(1, 6'h00, 32'h20, q);
        rreq <= 4'b0100;
        settle();
        chk(run, 1'b1);
        pins <= 5'h02;
        settle();
        chk({force_on, run, freq}, {2'b10, 16'h0200});
        pins <= 5'h00;
        settle();
        chk({force_on, run, freq}, {2'b01, 16'h0100});
        mrun <= 1;
        pins <= 5'h02;
        settle();
        chk({force_on, run}, 2'b00);
        bus(0, 6'h18, 0, q); chk(q, 32'h00040100);
        mrun <= 0;
        settle();
        chk(force_on, 1'b1);
        pins <= 5'h00;
        settle();
    endtask

    task automatic t_outputs;
        for (int k = 0; k < 9; k++) begin
            bus(1, 6'h14, 32'h5 | (k << 4) | (k << 8), q);
            sig <= 9'h1 << k;
            settle();
            chk({coil, oc}, {2'b11, k == 5});
            sig <= 9'h0;
            settle();
            chk({coil, oc, nc_c}, 4'b0001);
        end
        bus(1, 6'h14, 32'h1005, q);
        settle();
        chk(coil, 1'b1);
        sig <= 9'h1;
        settle();
        chk(coil, 1'b0);
    endtask

    initial begin
        rst = 1;
        {cyc, stb, we, mrun} = 0;
        adr = 0;
        sel = 0;
        wdat = 0;
        pins = 0;
        rreq = 0;
        sig = 0;
        for (int k = 0; k < 5; k++) srcf[k] = 16'h0100 * (k + 1);
        srcf[1] = 16'h0200;
        repeat (10) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        t_reset();
        srcf[1] <= 16'h0200;
        t_force();
        srcf[1] <= 16'h0200;
        t_outputs();
        t_offset();
        results();
    end
endmodule
